// ### verilog/xu_core.sv
// Purpose: exception sequencing for a 16-bit cpu core
// Assumes: cpu reports instruction ends, accesses and ops as pulses
// Notes:   stacking and vector reads are done by the cpu on xu_enter
`timescale 1ns/1ps
module xu_core
   import xu_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         arst_n,
   input  wire logic         single_chip_mode,
   input  wire logic         max_mode,
   input  wire logic         ram_enable,
   input  wire logic         acc_valid,
   input  wire logic         acc_prefetch,
   input  wire logic         acc_word,
   input  wire logic [15:0]  acc_addr,
   input  wire logic         instr_done,
   input  wire logic [15:0]  next_pc_in,
   input  wire logic [15:0]  detect_pc_in,
   input  wire logic [15:0]  status_word,
   input  wire logic         op_ctrl,
   input  wire logic         op_invalid,
   input  wire logic         op_vectored_trap_op,
   input  wire logic [3:0]   vectored_trap_op_vec,
   input  wire logic         op_trapvs,
   input  wire logic         ovf_flag,
   input  wire logic         op_divu,
   input  wire logic         divisor_zero,
   input  wire logic         nmi_req,
   input  wire logic [40:0]  int_pend,
   input  wire logic [40:0]  transfer_enable_bits,
   input  wire logic [3:0]   lvl_pin_a,
   input  wire logic [3:0]   lvl_pins_shared,
   input  wire logic [155:0] lvl_mod,
   input  wire logic         xfer_done,
   input  wire logic         entry_done,
   output logic              xu_enter,
   output logic [7:0]        xu_vector,
   output logic [15:0]       xu_saved_pc,
   output logic              xu_save_page,
   output logic              xu_clear_trace,
   output logic              xfer_start,
   output logic [5:0]        xfer_src,
   output logic              cpu_halt,
   output logic              int_ack,
   output logic [5:0]        int_ack_src
);
   `include "xu_cfg.svh"
   logic rst_m;
   logic rst_n;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   xu_arb_if arb_bus();
   xu_arbiter u_arb (
      .pend            (int_pend),
      .xfer_en         (transfer_enable_bits),
      .lvl_pin_a       (lvl_pin_a),
      .lvl_pins_shared (lvl_pins_shared),
      .lvl_mod         (lvl_mod),
      .mask_level      (status_word[10:8]),
      .arb             (arb_bus.arb)
   );

   // address checks on each access
   logic in_regs;
   logic in_hole;
   logic odd_word;
   logic acc_err;
   logic pf_err;
   always_comb begin
      in_regs  = acc_addr >= `XU_REG_AREA_LO;
      in_hole  = single_chip_mode && acc_addr >= `XU_HOLE_LO &&
                 acc_addr <= (ram_enable ? `XU_HOLE_HI : `XU_HOLE_NORAM_HI);
      odd_word = acc_word && !acc_prefetch && acc_addr[0];
      // prefetch of the last rom bytes lands in the hole here
      pf_err   = acc_valid && acc_prefetch && (in_regs || in_hole);
      acc_err  = acc_valid && (pf_err || odd_word || (!acc_prefetch && in_hole));
   end

   // sticky state
   xu_state_t state;
   xu_state_t next_state;
   logic      addr_err_pend;
   logic      next_addr_err_pend;
   logic      hold;
   logic      next_hold;
   logic      trace_skip;
   logic      next_trace_skip;
   logic      nmi_pend;
   logic      next_nmi_pend;
   logic      ctrl_seen;
   logic      next_ctrl_seen;
   logic      enter_r;
   logic      next_enter;
   logic [7:0]  vec_r;
   logic [7:0]  next_vec;
   logic [15:0] pc_r;
   logic [15:0] next_pc;
   logic        xs_r;
   logic        next_xs;
   logic [5:0]  xsrc_r;
   logic [5:0]  next_xsrc;
   logic        ack_r;
   logic        next_ack;
   logic [5:0]  asrc_r;
   logic [5:0]  next_asrc;

   logic trace_on;
   logic instr_exc;
   assign trace_on  = status_word[`XU_SW_TRACE_BIT];
   assign instr_exc = op_invalid || op_vectored_trap_op || (op_trapvs && ovf_flag) ||
                      (op_divu && divisor_zero);

   always_comb begin
      next_state         = state;
      next_addr_err_pend = addr_err_pend || acc_err;
      next_nmi_pend      = nmi_pend || nmi_req;
      next_hold          = hold;
      next_trace_skip    = trace_skip;
      next_ctrl_seen     = ctrl_seen;
      next_enter         = 1'b0;
      next_vec           = vec_r;
      next_pc            = pc_r;
      next_xs            = 1'b0;
      next_xsrc          = xsrc_r;
      next_ack           = 1'b0;
      next_asrc          = asrc_r;
      case (state)
         XU_RUN: begin
            if (instr_exc) begin
               // instruction exceptions enter at once; interrupts wait
               next_state = XU_ENTRY;
               next_enter = 1'b1;
               next_pc    = op_invalid ? detect_pc_in : next_pc_in;
               if (op_invalid) begin
                  next_vec = `XU_VEC_INVALID;
               end else if (op_vectored_trap_op) begin
                  next_vec = `XU_VEC_VECTORED_TRAP_OP + {4'h0, vectored_trap_op_vec};
               end else if (op_trapvs && ovf_flag) begin
                  next_vec = `XU_VEC_TRAPVS;
               end else begin
                  next_vec = `XU_VEC_ZDIV;
               end
            end else if (instr_done) begin
               // a held boundary lets exactly one non-control instruction finish; the end of
               // the first non-control instruction closes the hold and may take
               // an event, so nothing is deferred by a second non-control instruction
               next_hold      = op_ctrl;
               next_ctrl_seen = op_ctrl;
               if (op_ctrl) begin
                  // control ops chain: nothing is taken at their end
                  next_hold = 1'b1;
               end else if (addr_err_pend || acc_err) begin
                  next_state = XU_ENTRY;
                  next_enter = 1'b1;
                  next_vec   = `XU_VEC_ADDR_ERR;
                  next_pc    = next_pc_in;
                  next_addr_err_pend = 1'b0;
                  // only a trace that lost to the error is skipped once
                  next_trace_skip    = trace_on;
               end else if (nmi_pend || nmi_req) begin
                  next_state = XU_ENTRY;
                  next_enter = 1'b1;
                  next_vec   = `XU_VEC_NMI;
                  next_pc    = next_pc_in;
                  next_nmi_pend = 1'b0;
               end else if (arb_bus.req && arb_bus.xfer) begin
                  next_state = XU_XFER;
                  next_xs    = 1'b1;
                  next_xsrc  = arb_bus.src;
               end else if (arb_bus.req) begin
                  next_state = XU_ENTRY;
                  next_enter = 1'b1;
                  next_vec   = `XU_VEC_INT_BASE + {2'h0, arb_bus.src};
                  next_pc    = next_pc_in;
                  next_ack   = 1'b1;
                  next_asrc  = arb_bus.src;
               end else if (trace_on && !trace_skip) begin
                  next_state = XU_ENTRY;
                  next_enter = 1'b1;
                  next_vec   = `XU_VEC_TRACE;
                  next_pc    = next_pc_in;
               end else begin
                  // restored status word re-arms trace one instruction late
                  next_trace_skip = 1'b0;
               end
            end
         end
         XU_XFER: begin
            if (xfer_done) begin
               next_state = XU_RUN;
               next_hold  = 1'b1;
            end
         end
         XU_ENTRY: begin
            if (entry_done) begin
               next_state = XU_RUN;
               next_hold  = next_ctrl_seen;
            end
         end
         default: next_state = XU_RUN;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state         <= XU_RUN;
         addr_err_pend <= 1'b0;
         hold          <= 1'b1;     // first instruction always runs
         trace_skip    <= 1'b0;
         nmi_pend      <= 1'b0;
         ctrl_seen     <= 1'b0;
         enter_r       <= 1'b0;
         vec_r         <= 8'h00;
         pc_r          <= 16'h0000;
         xs_r          <= 1'b0;
         xsrc_r        <= 6'h00;
         ack_r         <= 1'b0;
         asrc_r        <= 6'h00;
      end else begin
         state         <= next_state;
         addr_err_pend <= next_addr_err_pend;
         hold          <= next_hold;
         trace_skip    <= next_trace_skip;
         nmi_pend      <= next_nmi_pend;
         ctrl_seen     <= next_ctrl_seen;
         enter_r       <= next_enter;
         vec_r         <= next_vec;
         pc_r          <= next_pc;
         xs_r          <= next_xs;
         xsrc_r        <= next_xsrc;
         ack_r         <= next_ack;
         asrc_r        <= next_asrc;
      end
   end

   assign xu_enter       = enter_r;
   assign xu_vector      = vec_r;
   assign xu_saved_pc    = pc_r;
   assign xu_save_page   = enter_r && max_mode;
   assign xu_clear_trace = enter_r;
   assign xfer_start     = xs_r;
   assign xfer_src       = xsrc_r;
   assign cpu_halt       = state != XU_RUN;
   assign int_ack        = ack_r;
   assign int_ack_src    = asrc_r;

   a_reset_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(rst_n) |-> hold) else $error("hold not set after reset");
   a_hold_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (hold && state == XU_RUN && !instr_exc && !(instr_done && !op_ctrl)) |=> !enter_r && !xs_r)
      else $error("entry during hold");
   a_xfer_halts: assert property (@(posedge clk_sys) disable iff (!rst_n)
      xs_r |-> cpu_halt) else $error("no halt during transfer");
   a_xfer_then_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_XFER && xfer_done) |=> hold) else $error("no hold after transfer");
   a_trap_vec: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_RUN && op_vectored_trap_op && !op_invalid) |=> enter_r && vec_r == `XU_VEC_VECTORED_TRAP_OP + {4'h0, $past(vectored_trap_op_vec)})
      else $error("wrong trap vector");
   a_vs_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_RUN && op_trapvs && !ovf_flag && !op_invalid && !op_vectored_trap_op && !(op_divu && divisor_zero)
       && !instr_done) |=> !enter_r) else $error("trap with clear flag");
   a_invalid_pc: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_RUN && op_invalid) |=> pc_r == $past(detect_pc_in)) else $error("bad invalid pc");
   a_regs_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (acc_valid && acc_prefetch && acc_addr >= 16'hFE80) |=> addr_err_pend || enter_r)
      else $error("register prefetch missed");
   a_page_save: assert property (@(posedge clk_sys) disable iff (!rst_n)
      xu_enter |-> xu_save_page == max_mode) else $error("page save mismatch");

   // event selection at an instruction end
   a_addr_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_RUN && instr_done && !op_ctrl && !instr_exc && (addr_err_pend || acc_err))
      |=> enter_r && vec_r == `XU_VEC_ADDR_ERR) else $error("address error not taken first");
   a_nmi_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_RUN && instr_done && !op_ctrl && !instr_exc && !addr_err_pend && !acc_err &&
       (nmi_pend || nmi_req)) |=> enter_r && vec_r == `XU_VEC_NMI) else $error("nmi not taken");
   a_trace_last: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_RUN && instr_done && !op_ctrl && !instr_exc && !addr_err_pend && !acc_err &&
       !nmi_pend && !nmi_req && !arb_bus.req && trace_on && !trace_skip)
      |=> enter_r && vec_r == `XU_VEC_TRACE) else $error("trace not taken");
   a_ctrl_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_RUN && instr_done && op_ctrl && !instr_exc) |=> !enter_r && !xs_r && hold)
      else $error("event taken at control op end");
   a_hold_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_RUN && instr_done && !op_ctrl && !instr_exc) |=> !hold)
      else $error("hold outlives one instruction");
   // the controller and an entry never start together
   a_xfer_alone: assert property (@(posedge clk_sys) disable iff (!rst_n)
      xs_r |-> !enter_r && !ack_r) else $error("entry with transfer start");
   a_ack_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ack_r |-> enter_r && vec_r == `XU_VEC_INT_BASE + {2'h0, asrc_r}) else $error("ack vector mismatch");
   a_zdiv_vec: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == XU_RUN && op_divu && divisor_zero && !op_invalid && !op_vectored_trap_op && !(op_trapvs && ovf_flag))
      |=> enter_r && vec_r == `XU_VEC_ZDIV) else $error("zero divide vector");
   // access errors are remembered until an instruction end takes them
   a_odd_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (acc_valid && acc_word && !acc_prefetch && acc_addr[0]) |=> addr_err_pend || enter_r)
      else $error("odd word access missed");
   a_hole_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (acc_valid && single_chip_mode && ram_enable && acc_addr >= 16'hEE80 && acc_addr <= 16'hF67F)
      |=> addr_err_pend || enter_r) else $error("hole access missed");
   a_hole_noram: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (acc_valid && single_chip_mode && !ram_enable && acc_addr >= 16'hEE80 && acc_addr <= 16'hFE7F)
      |=> addr_err_pend || enter_r) else $error("widened hole access missed");
endmodule

// ### verilog/xu_cfg.svh
// Purpose: constants of the exception unit
// Assumes: 16-bit address space
// Notes:   definitions only
`ifndef XU_CFG_SVH
`define XU_CFG_SVH
`define XU_REG_AREA_LO   16'hFE80
`define XU_REG_AREA_HI   16'hFFFF
`define XU_HOLE_LO       16'hEE80
`define XU_HOLE_HI       16'hF67F
`define XU_HOLE_NORAM_HI 16'hFE7F
`define XU_PREFETCH_SPAN 16'h0002
`define XU_NMI_LEVEL     4'h8
`define XU_N_INT_SRC     41
`define XU_N_MOD_SRC     39
`define XU_VEC_ADDR_ERR  8'h08
`define XU_VEC_TRACE     8'h09
`define XU_VEC_NMI       8'h0B
`define XU_VEC_INVALID   8'h02
`define XU_VEC_ZDIV      8'h03
`define XU_VEC_TRAPVS    8'h04
`define XU_VEC_VECTORED_TRAP_OP     8'h10
`define XU_VEC_INT_BASE  8'h20
`define XU_SW_TRACE_BIT  15
`endif

// ### verilog/xu_pkg.sv
// Purpose: types of the exception unit
// Assumes: nothing
// Notes:   constants live in xu_cfg.svh
package xu_pkg;
   typedef enum logic [1:0] {
      XU_RUN   = 2'b00,
      XU_XFER  = 2'b01,
      XU_ENTRY = 2'b11
   } xu_state_t;
   typedef enum logic [2:0] {
      XU_K_NONE   = 3'h0,
      XU_K_ADDR   = 3'h1,
      XU_K_TRACE  = 3'h2,
      XU_K_INT    = 3'h3,
      XU_K_INSTR  = 3'h4
   } xu_kind_t;
endpackage

// ### verilog/xu_arb_if.sv
// Purpose: carrier between the arbiter and the exception core
// Assumes: one clock domain
// Notes:   none
`timescale 1ns/1ps
interface xu_arb_if;
   import xu_pkg::*;
   logic       req;
   logic [3:0] level;
   logic [5:0] src;
   logic       xfer;
   modport arb  (output req, output level, output src, output xfer);
   modport core (input req, input level, input src, input xfer);
endinterface

// ### verilog/xu_arbiter.sv
// Purpose: picks the highest-level maskable interrupt source
// Assumes: lower source index wins a tie on equal level
// Notes:   combinational
`timescale 1ns/1ps
module xu_arbiter
   import xu_pkg::*;
(
   input  wire logic [40:0]    pend,
   input  wire logic [40:0]    xfer_en,
   input  wire logic [3:0]     lvl_pin_a,
   input  wire logic [3:0]     lvl_pins_shared,
   input  wire logic [155:0]   lvl_mod,
   input  wire logic [2:0]     mask_level,
   xu_arb_if.arb               arb
);
   `include "xu_cfg.svh"
   logic [3:0] lvl_of [41];
   always_comb begin
      lvl_of[0] = lvl_pin_a;
      lvl_of[1] = lvl_pins_shared;
      for (int i = 0; i < `XU_N_MOD_SRC; i++) begin
         lvl_of[i + 2] = lvl_mod[i*4 +: 4];
      end
   end
   always_comb begin
      arb.req   = 1'b0;
      arb.level = 4'h0;
      arb.src   = 6'h00;
      arb.xfer  = 1'b0;
      for (int i = 0; i < `XU_N_INT_SRC; i++) begin
         // level 0 never passes; a pending transfer ignores the mask
         if (pend[i] && lvl_of[i] != 4'h0 && lvl_of[i] > arb.level &&
             (xfer_en[i] || lvl_of[i] > {1'b0, mask_level})) begin
            arb.req   = 1'b1;
            arb.level = lvl_of[i];
            arb.src   = 6'(i);
            arb.xfer  = xfer_en[i];
         end
      end
   end
endmodule

// ### dv/xu_partner.sv
// Purpose: far side of the exception unit: stacking sequencer and transfer controller
// Assumes: one clock, requests arrive as one-cycle pulses
// Notes:   slow stretches both answers so long halts are exercised too
`timescale 1ns/1ps
module xu_partner (
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic slow,
   input  wire logic xu_enter,
   input  wire logic xfer_start,
   output logic      entry_done,
   output logic      xfer_done
);
   logic [3:0] ent_cnt;
   logic [3:0] xf_cnt;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ent_cnt    <= 4'h0;
         xf_cnt     <= 4'h0;
         entry_done <= 1'b0;
         xfer_done  <= 1'b0;
      end else begin
         entry_done <= (ent_cnt == 4'h1);
         xfer_done  <= (xf_cnt == 4'h1);
         ent_cnt    <= xu_enter ? (slow ? 4'h9 : 4'h2) : ent_cnt - {3'h0, ent_cnt != 4'h0};
         xf_cnt     <= xfer_start ? (slow ? 4'h9 : 4'h2) : xf_cnt - {3'h0, xf_cnt != 4'h0};
      end
   end
endmodule

// ### dv/cpu_exception_unit_tb.sv
// Purpose: self-checking bench of the exception unit
// Assumes: partner answers entries and transfers after a short or long wait
// Notes:   addresses are checked from a table of boundary cases
`timescale 1ns/1ps
`include "xu_cfg.svh"
module cpu_exception_unit_tb;
   logic         clk_sys, arst_n, single_chip_mode, max_mode, ram_enable, slow;
   logic         acc_valid, acc_prefetch, acc_word, instr_done, op_ctrl, op_invalid;
   logic         op_vectored_trap_op, op_trapvs, ovf_flag, op_divu, divisor_zero, nmi_req;
   logic         entry_done, xfer_done, xu_enter, xu_save_page, xu_clear_trace;
   logic         xfer_start, cpu_halt, int_ack;
   logic [3:0]   vectored_trap_op_vec, lvl_pin_a, lvl_pins_shared;
   logic [5:0]   xfer_src, int_ack_src;
   logic [7:0]   xu_vector;
   logic [15:0]  acc_addr, next_pc_in, detect_pc_in, status_word, xu_saved_pc;
   logic [40:0]  int_pend, transfer_enable_bits;
   logic [155:0] lvl_mod;
   int           errors, checks;
   // single-chip, ram on, prefetch, word, error expected, address
   localparam logic [20:0] TBL [14] = '{
      {5'b00101, 16'hFE80}, {5'b00101, 16'hFFFF}, {5'b00100, 16'hFE7B},
      {5'b00011, 16'h1235}, {5'b00010, 16'h1234}, {5'b00000, 16'h1235},
      {5'b11001, 16'hEE80}, {5'b11011, 16'hF67E}, {5'b11001, 16'hF67F}, {5'b11000, 16'hF680},
      {5'b01000, 16'hEE80}, {5'b10001, 16'hF680}, {5'b10011, 16'hFE7E},
      {5'b11101, 16'hEE82}};

   xu_partner u_far (.clk_sys, .arst_n, .slow, .xu_enter, .xfer_start, .entry_done, .xfer_done);
   xu_core dut (.clk_sys, .arst_n, .single_chip_mode, .max_mode, .ram_enable, .acc_valid, .acc_prefetch,
      .acc_word, .acc_addr, .instr_done, .next_pc_in, .detect_pc_in, .status_word, .op_ctrl, .op_invalid,
      .op_vectored_trap_op, .vectored_trap_op_vec, .op_trapvs, .ovf_flag, .op_divu, .divisor_zero, .nmi_req, .int_pend,
      .transfer_enable_bits, .lvl_pin_a, .lvl_pins_shared, .lvl_mod, .xfer_done, .entry_done, .xu_enter,
      .xu_vector, .xu_saved_pc, .xu_save_page, .xu_clear_trace, .xfer_start, .xfer_src, .cpu_halt,
      .int_ack, .int_ack_src);

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // 1 ns after the taking edge, then wait out the halt
   task automatic see(input logic en, input logic [7:0] v);
      int n;
      n = 0;
      #1;
      chk(xu_enter, en);
      chk(int_ack, en && v >= `XU_VEC_INT_BASE);
      if (en) begin
         chk(xu_vector, v);
         chk(xu_clear_trace, 1'b1);
         chk(xu_save_page, max_mode);
      end
      while (cpu_halt !== 1'b0 && n < 40) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(cpu_halt, 1'b0);
   endtask

   task automatic step(input logic ctrl, input logic en, input logic [7:0] v);
      @(posedge clk_sys);
      instr_done <= 1'b1;
      op_ctrl    <= ctrl;
      @(posedge clk_sys);
      instr_done <= 1'b0;
      op_ctrl    <= 1'b0;
      see(en, v);
   endtask

   task automatic op(input logic [3:0] sel, input logic en, input logic [7:0] v);
      @(posedge clk_sys);
      {op_invalid, op_vectored_trap_op, op_trapvs, op_divu} <= sel;
      @(posedge clk_sys);
      {op_invalid, op_vectored_trap_op, op_trapvs, op_divu} <= 4'h0;
      see(en, v);
   endtask

   task automatic nmi();
      @(posedge clk_sys);
      nmi_req <= 1'b1;
      @(posedge clk_sys);
      nmi_req <= 1'b0;
   endtask

   // mode straps settle a cycle before the access
   task automatic acc(input logic [20:0] e);
      @(posedge clk_sys);
      {single_chip_mode, ram_enable} <= e[20:19];
      @(posedge clk_sys);
      {acc_valid, acc_prefetch, acc_word, acc_addr} <= {1'b1, e[18:17], e[15:0]};
      @(posedge clk_sys);
      acc_valid <= 1'b0;
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // whole run needs a few hundred cycles
   initial begin
      repeat (30000) @(posedge clk_sys);
      errors++;
      test_done();
   end

   initial begin
      errors = 0;
      checks = 0;
      arst_n = 1'b0;
      {single_chip_mode, max_mode, ram_enable, slow, acc_valid, acc_prefetch, acc_word, instr_done} = '0;
      {op_ctrl, op_invalid, op_vectored_trap_op, op_trapvs, ovf_flag, op_divu, divisor_zero, nmi_req} = '0;
      {vectored_trap_op_vec, lvl_pin_a, lvl_pins_shared, acc_addr, status_word} = '0;
      {int_pend, transfer_enable_bits, lvl_mod} = '0;
      next_pc_in = 16'h1234;
      detect_pc_in = 16'h5678;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      nmi();
      repeat (4) begin
         @(posedge clk_sys);
         #1;
         chk(xu_enter, 1'b0);
      end
      step(1'b0, 1'b1, `XU_VEC_NMI);
      $display("test reset done");
      for (int i = 0; i < 14; i++) begin
         acc(TBL[i]);
         step(1'b0, TBL[i][16], `XU_VEC_ADDR_ERR);
         if (TBL[i][16]) chk(xu_saved_pc, next_pc_in);
      end
      $display("test address done");
      @(posedge clk_sys);
      status_word <= 16'h8000;
      step(1'b0, 1'b1, `XU_VEC_TRACE);
      acc(TBL[0]);
      step(1'b0, 1'b1, `XU_VEC_ADDR_ERR);
      step(1'b0, 1'b0, 8'h00);
      step(1'b0, 1'b1, `XU_VEC_TRACE);
      $display("test trace done");
      @(posedge clk_sys);
      {max_mode, status_word, lvl_mod} <= {1'b1, 16'h0500, 156'h50};
      int_pend[3] <= 1'b1;
      step(1'b0, 1'b0, 8'h00);
      @(posedge clk_sys);
      {status_word, lvl_pins_shared} <= {16'h0400, 4'h5};
      int_pend[1] <= 1'b1;
      step(1'b0, 1'b1, `XU_VEC_INT_BASE + 8'h01);
      chk(int_ack_src, 16'h0001);
      @(posedge clk_sys);
      {int_pend[1], int_pend[0], lvl_pin_a} <= {1'b0, 1'b1, 4'h6};
      step(1'b0, 1'b1, `XU_VEC_INT_BASE);
      @(posedge clk_sys);
      int_pend[0] <= 1'b0;
      step(1'b0, 1'b1, `XU_VEC_INT_BASE + 8'h03);
      @(posedge clk_sys);
      status_word <= 16'h0700;
      nmi();
      step(1'b0, 1'b1, `XU_VEC_NMI);
      $display("test priority done");
      @(posedge clk_sys);
      {status_word, slow} <= {16'h0000, 1'b1};
      transfer_enable_bits[3] <= 1'b1;
      instr_done <= 1'b1;
      @(posedge clk_sys);
      instr_done <= 1'b0;
      #1;
      chk(xfer_start, 1'b1);
      chk(xu_enter, 1'b0);
      chk(xfer_src, 16'h0003);
      chk(cpu_halt, 1'b1);
      @(posedge clk_sys);
      int_pend[3] <= 1'b0;
      nmi_req <= 1'b1;
      @(posedge clk_sys);
      nmi_req <= 1'b0;
      see(1'b0, 8'h00);
      step(1'b0, 1'b1, `XU_VEC_NMI);
      nmi();
      step(1'b1, 1'b0, 8'h00);
      step(1'b1, 1'b0, 8'h00);
      step(1'b0, 1'b1, `XU_VEC_NMI);
      $display("test deferral done");
      op(4'h8, 1'b1, `XU_VEC_INVALID);
      chk(xu_saved_pc, detect_pc_in);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_sys);
         vectored_trap_op_vec <= 4'(i);
         op(4'h4, 1'b1, `XU_VEC_VECTORED_TRAP_OP + 8'(i));
      end
      op(4'h2, 1'b0, 8'h00);
      @(posedge clk_sys);
      {ovf_flag, divisor_zero} <= 2'b11;
      op(4'h2, 1'b1, `XU_VEC_TRAPVS);
      op(4'h1, 1'b1, `XU_VEC_ZDIV);
      @(posedge clk_sys);
      {divisor_zero, int_pend[3], transfer_enable_bits[3]} <= 3'b010;
      op(4'h1, 1'b0 | 1'b0, 8'h00);
      @(posedge clk_sys);
      op_vectored_trap_op <= 1'b0;
      op(4'h4, 1'b1, `XU_VEC_VECTORED_TRAP_OP + 8'h0F);
      step(1'b0, 1'b1, `XU_VEC_INT_BASE + 8'h03);
      $display("test instruction done");
      test_done();
   end
endmodule
